/* File: sbl_defs.svh */
`ifndef SBL_DEFS_SVH
`define SBL_DEFS_SVH
`define SBL_AW 8
`define SBL_OFF_CFG 8'h00
`define SBL_OFF_NUM 8'h04
`define SBL_OFF_DEN 8'h08
`define SBL_OFF_BST 8'h0c
`define SBL_OFF_PWR 8'h10
`define SBL_OFF_FLT 8'h14
`define SBL_OFF_STAT 8'h18
`define SBL_CFG_SELECT_A 1:0
`define SBL_CFG_WIDE 2
`define SBL_CFG_HALF 3
`define SBL_CFG_ORDER 5:4
`define SBL_CFG_FLTEN 6
`define SBL_FRAC 21:0
`define SBL_BST_TOC 13:0
`define SBL_BST_BOOST_PUMP_CURRENT_CODE 17:14
`define SBL_BST_ICP 21:18
`define SBL_PWR_EN 6:0
`define SBL_PWR_SRST 7
`define SBL_FLT_CAP 2:0
`define SBL_FLT_R1 4:3
`define SBL_FLT_R1B 6:5
`define SBL_FLT_R2 8:7
`define SBL_FLT_R2B 10:9
`define SBL_NARROW 11:0
`define SBL_RST_SELECT_A 2'h0
`define SBL_RST_ORDER 2'h3
`define SBL_RST_FRAC 22'h000000
`define SBL_RST_TOC 14'h0000
`define SBL_RST_ICP 4'h0
`define SBL_RST_PWR 7'h7f
`define SBL_RST_CAP 3'h0
`define SBL_RST_RES 2'h0
`define SBL_SELECT_A_WEAK 2'h0
`define SBL_SELECT_A_STRONG 2'h2
`define SBL_SELECT_A_OFF 2'h3
`define SBL_ORDER_INT 2'h1
`define SBL_TOC_HIZ 14'h0000
`define SBL_TOC_FOREVER 14'h0001
`define SBL_TOC_HIGH 14'h0003
`define SBL_TOC_MIN 14'h0004
`define SBL_R_STEP_KOHM 6'h0a
`define SBL_CAP_50 8'h32
`define SBL_CAP_100 8'h64
`define SBL_CAP_150 8'h96
`define SBL_CAP_SUM_OFF 8'hc8
`endif

/* File: sbl_host_model.sv */
`include "sbl_defs.svh"
`default_nettype none
module sbl_host_model (
    input wire logic i_clk,
    output logic [7:0] o_addr,
    output logic [31:0] o_wdata,
    output logic o_wr_stb,
    output logic o_rd_stb
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        o_addr = 8'h00;
        o_wdata = 32'h0000_0000;
        o_wr_stb = 1'b0;
        o_rd_stb = 1'b0;
    end
    // Callers pass only legal selector codes; init writes the soft-reset bit set, then clear.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr_stb <= 1'b1;
        @(posedge i_clk);
        o_wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk);
        o_addr <= a;
        o_rd_stb <= 1'b1;
        @(posedge i_clk);
        o_rd_stb <= 1'b0;
    endtask
    // Start-up takes three power writes: reset, release, then enable.
    task automatic init(input logic [6:0] en);
        wr(`SBL_OFF_PWR, 32'h0000_0080);
        wr(`SBL_OFF_PWR, 32'h0000_0000);
        wr(`SBL_OFF_PWR, {25'h0, en});
    endtask
    // Dithering stays on unless the numerator is zero.
    function automatic logic [1:0] pick_select_a(input logic [21:0] num);
        return (num == 22'h0) ? `SBL_SELECT_A_OFF : `SBL_SELECT_A_STRONG;
    endfunction
endmodule
`default_nettype wire

/* File: sbl_pkg.sv */
`default_nettype none
package sbl_pkg;
    typedef enum logic [1:0] {
        SBL_DITH_WEAK = 2'h0,
        SBL_DITH_STRONG = 2'h1,
        SBL_DITH_OFF = 2'h2
    } sbl_select_a_e;
    typedef enum logic [1:0] {
        SBL_ST_STEADY = 2'h0,
        SBL_ST_TIMED = 2'h1,
        SBL_ST_FOREVER = 2'h3
    } sbl_boost_e;
    typedef struct packed {
        sbl_select_a_e select_a;
        logic output_halving;
        logic mod_reset;
        logic [21:0] frac_num;
        logic [21:0] frac_den;
    } sbl_loop_s;
    typedef struct packed {
        logic [3:0] pump_code;
        logic poles_on;
        logic [5:0] r1_kohm;
        logic [5:0] r2_kohm;
        logic [7:0] c3_pf;
        logic [7:0] c4_pf;
    } sbl_filter_s;
    typedef struct packed {
        logic pll_loop_enable;
        logic osc_core_power_enable;
        logic ref_osc_power_enable;
        logic osc_core_regulator_enable;
        logic loop_regulator_one_enable;
        logic loop_regulator_two_enable;
        logic digital_regulator_enable;
    } sbl_power_s;
endpackage
`default_nettype wire

/* File: sbl_synth_cfg.sv */
`include "sbl_defs.svh"
`default_nettype none
// Summary of operation
// - Select_a code 0 weak, 2 strong, 3 off; code 1 reserved.
// - Wide fraction mode uses all 22 numerator and denominator bits.
// - Narrow mode uses only the low 12 fraction bits.
// - Narrow mode ignores the upper denominator bits.
// - Output halving 0 passes the oscillator, 1 divides by two.
// - Timeout word of 0, 2 or 3 disables boost-lock; pin is plain output.
// - Word 0 high impedance, 1 and 2 low, 3 high; 1 stays engaged.
// - Word 4 or more engages boost for twice the word in detector cycles.
// - While counting: pin grounded, boost current and boost resistor codes.
// - Boost current code n gives n+1 times unit current.
// - Loop, oscillator core and reference enables default to 1.
// - Four regulator enables: 1 powers up, 0 powers down.
// - Soft-reset written 1 restores defaults and powers the part down.
// - Capacitor selector decodes to the listed capacitor pairs.
// - Each resistor code 0 to 3 selects 10 to 40 kilohms.
// - Filter disabled shorts resistors and totals 200 pF.
// - Modulator order 1 resets modulator and ignores fractions.
module sbl_synth_cfg (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [`SBL_AW-1:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr_stb,
    input wire logic i_rd_stb,
    output logic [31:0] o_rdata,
    input wire logic i_pd_tick,
    output var sbl_pkg::sbl_loop_s o_loop,
    output var sbl_pkg::sbl_filter_s o_filter,
    output var sbl_pkg::sbl_power_s o_power,
    output logic o_boost_lock_pin_o,
    output logic o_boost_lock_pin_oe
);
    function automatic logic hit(input logic [`SBL_AW-1:0] a, input logic [`SBL_AW-1:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [5:0] res_kohm(input logic [1:0] code);
        res_kohm = ({4'h0, code} + 6'h01) * `SBL_R_STEP_KOHM;
    endfunction

    function automatic logic [21:0] frac_eff(input logic [21:0] v, input logic wide);
        frac_eff = wide ? v : {10'h000, v[`SBL_NARROW]};
    endfunction

    logic [1:0] select_a_q;
    logic wide_q;
    logic halving_q;
    logic [1:0] order_q;
    logic flten_q;
    logic [21:0] num_q;
    logic [21:0] den_q;
    logic [13:0] toc_q;
    logic [3:0] boost_pump_current_code_q;
    logic [3:0] icp_q;
    logic [6:0] pwr_q;
    logic srst_q;
    logic [2:0] cap_q;
    logic [1:0] r1_q;
    logic [1:0] r1b_q;
    logic [1:0] r2_q;
    logic [1:0] r2b_q;
    sbl_pkg::sbl_boost_e st_q;
    sbl_pkg::sbl_boost_e st_d;
    logic [14:0] cnt_q;
    logic [14:0] cnt_d;

    wire wr_cfg = i_wr_stb && hit(i_addr, `SBL_OFF_CFG);
    wire wr_num = i_wr_stb && hit(i_addr, `SBL_OFF_NUM);
    wire wr_den = i_wr_stb && hit(i_addr, `SBL_OFF_DEN);
    wire wr_bst = i_wr_stb && hit(i_addr, `SBL_OFF_BST);
    wire wr_pwr = i_wr_stb && hit(i_addr, `SBL_OFF_PWR);
    wire wr_flt = i_wr_stb && hit(i_addr, `SBL_OFF_FLT);
    wire srst_wr = wr_pwr && i_wdata[`SBL_PWR_SRST];
    wire freq_wr = wr_num || wr_den;
    wire toc_long = (toc_q >= `SBL_TOC_MIN);
    wire boost_on = (st_q != sbl_pkg::SBL_ST_STEADY);
    wire order_int = (order_q == `SBL_ORDER_INT);

    // Configuration registers; a soft-reset write restores every default.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst || srst_wr)
        begin
            select_a_q <= `SBL_RST_SELECT_A;
            wide_q <= 1'b0;
            halving_q <= 1'b0;
            order_q <= `SBL_RST_ORDER;
            flten_q <= 1'b1;
            num_q <= `SBL_RST_FRAC;
            den_q <= `SBL_RST_FRAC;
            toc_q <= `SBL_RST_TOC;
            boost_pump_current_code_q <= `SBL_RST_ICP;
            icp_q <= `SBL_RST_ICP;
            pwr_q <= `SBL_RST_PWR;
            cap_q <= `SBL_RST_CAP;
            r1_q <= `SBL_RST_RES;
            r1b_q <= `SBL_RST_RES;
            r2_q <= `SBL_RST_RES;
            r2b_q <= `SBL_RST_RES;
        end
        else
        begin
            if (wr_cfg)
            begin
                select_a_q <= i_wdata[`SBL_CFG_SELECT_A];
                wide_q <= i_wdata[`SBL_CFG_WIDE];
                halving_q <= i_wdata[`SBL_CFG_HALF];
                order_q <= i_wdata[`SBL_CFG_ORDER];
                flten_q <= i_wdata[`SBL_CFG_FLTEN];
            end
            if (wr_num)
                num_q <= i_wdata[`SBL_FRAC];
            if (wr_den)
                den_q <= i_wdata[`SBL_FRAC];
            if (wr_bst)
            begin
                toc_q <= i_wdata[`SBL_BST_TOC];
                boost_pump_current_code_q <= i_wdata[`SBL_BST_BOOST_PUMP_CURRENT_CODE];
                icp_q <= i_wdata[`SBL_BST_ICP];
            end
            if (wr_pwr)
                pwr_q <= i_wdata[`SBL_PWR_EN];
            if (wr_flt)
            begin
                cap_q <= i_wdata[`SBL_FLT_CAP];
                r1_q <= i_wdata[`SBL_FLT_R1];
                r1b_q <= i_wdata[`SBL_FLT_R1B];
                r2_q <= i_wdata[`SBL_FLT_R2];
                r2b_q <= i_wdata[`SBL_FLT_R2B];
            end
        end
    end

    // The soft-reset bit itself is held until software writes it back to zero.
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            srst_q <= 1'b0;
        else if (wr_pwr)
            srst_q <= i_wdata[`SBL_PWR_SRST];
    end

    // Boost-lock sequencer counting phase-detector cycles.
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        if (srst_wr)
        begin
            st_d = sbl_pkg::SBL_ST_STEADY;
            cnt_d = 15'h0000;
        end
        else if (toc_q == `SBL_TOC_FOREVER)
            st_d = sbl_pkg::SBL_ST_FOREVER;
        else if (freq_wr && toc_long)
        begin
            st_d = sbl_pkg::SBL_ST_TIMED;
            cnt_d = {toc_q, 1'b0};
        end
        else if (!toc_long || st_q == sbl_pkg::SBL_ST_FOREVER)
        begin
            st_d = sbl_pkg::SBL_ST_STEADY;
            cnt_d = 15'h0000;
        end
        else if (st_q == sbl_pkg::SBL_ST_TIMED && i_pd_tick)
        begin
            cnt_d = cnt_q - 15'h0001;
            if (cnt_q == 15'h0001)
                st_d = sbl_pkg::SBL_ST_STEADY;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            st_q <= sbl_pkg::SBL_ST_STEADY;
            cnt_q <= 15'h0000;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Pin drive from the timeout word, or from the boost state when the word is long.
    logic pin_o_d;
    logic pin_oe_d;
    always_comb
    begin
        pin_o_d = 1'b0;
        pin_oe_d = 1'b1;
        case (toc_q)
            `SBL_TOC_HIZ: pin_oe_d = 1'b0;
            `SBL_TOC_HIGH: pin_o_d = 1'b1;
            default: pin_oe_d = (toc_q < `SBL_TOC_MIN) || boost_on;
        endcase
    end

    sbl_pkg::sbl_select_a_e select_a_d;
    always_comb
    begin
        case (select_a_q)
            `SBL_SELECT_A_WEAK: select_a_d = sbl_pkg::SBL_DITH_WEAK;
            `SBL_SELECT_A_STRONG: select_a_d = sbl_pkg::SBL_DITH_STRONG;
            default: select_a_d = sbl_pkg::SBL_DITH_OFF;
        endcase
    end

    logic [15:0] cap_pair;
    always_comb
    begin
        case (cap_q)
            3'h0: cap_pair = {`SBL_CAP_50, `SBL_CAP_50};
            3'h1: cap_pair = {`SBL_CAP_50, `SBL_CAP_100};
            3'h3: cap_pair = {`SBL_CAP_100, `SBL_CAP_50};
            3'h4: cap_pair = {`SBL_CAP_150, `SBL_CAP_50};
            3'h5: cap_pair = {`SBL_CAP_100, `SBL_CAP_100};
            default: cap_pair = {`SBL_CAP_50, `SBL_CAP_150};
        endcase
    end

    wire [1:0] r1_sel = boost_on ? r1b_q : r1_q;
    wire [1:0] r2_sel = boost_on ? r2b_q : r2_q;
    sbl_pkg::sbl_loop_s loop_d;
    sbl_pkg::sbl_filter_s filt_d;
    assign loop_d.select_a = select_a_d;
    assign loop_d.output_halving = halving_q;
    assign loop_d.mod_reset = order_int;
    assign loop_d.frac_num = order_int ? `SBL_RST_FRAC : frac_eff(num_q, wide_q);
    assign loop_d.frac_den = order_int ? `SBL_RST_FRAC : frac_eff(den_q, wide_q);
    assign filt_d.pump_code = boost_on ? boost_pump_current_code_q : icp_q;
    assign filt_d.poles_on = flten_q;
    assign filt_d.r1_kohm = flten_q ? res_kohm(r1_sel) : 6'h00;
    assign filt_d.r2_kohm = flten_q ? res_kohm(r2_sel) : 6'h00;
    assign filt_d.c3_pf = flten_q ? cap_pair[15:8] : `SBL_CAP_100;
    assign filt_d.c4_pf = flten_q ? cap_pair[7:0] : `SBL_CAP_100;
    wire [6:0] pwr_d = srst_q ? 7'h00 : pwr_q;

    logic [31:0] rd_d;
    always_comb
    begin
        rd_d = 32'h00000000;
        case (i_addr)
            `SBL_OFF_CFG: rd_d = {25'h0, flten_q, order_q, halving_q, wide_q, select_a_q};
            `SBL_OFF_NUM: rd_d = {10'h000, num_q};
            `SBL_OFF_DEN: rd_d = {10'h000, den_q};
            `SBL_OFF_BST: rd_d = {10'h000, icp_q, boost_pump_current_code_q, toc_q};
            `SBL_OFF_PWR: rd_d = {24'h0, srst_q, pwr_q};
            `SBL_OFF_FLT: rd_d = {21'h0, r2b_q, r2_q, r1b_q, r1_q, cap_q};
            `SBL_OFF_STAT: rd_d = {16'h0000, cnt_q, boost_on};
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            o_rdata <= 32'h00000000;
            o_loop <= '0;
            o_filter <= '0;
            o_power <= '0;
            o_boost_lock_pin_o <= 1'b0;
            o_boost_lock_pin_oe <= 1'b0;
        end
        else
        begin
            o_rdata <= i_rd_stb ? rd_d : 32'h00000000;
            o_loop <= loop_d;
            o_filter <= filt_d;
            o_power <= sbl_pkg::sbl_power_s'(pwr_d);
            o_boost_lock_pin_o <= pin_o_d;
            o_boost_lock_pin_oe <= pin_oe_d;
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    AST_SELECT_A_STRONG: assert property (
        select_a_q == `SBL_SELECT_A_STRONG |=> o_loop.select_a == sbl_pkg::SBL_DITH_STRONG)
        else $error("Strong select_a code not decoded.");
    AST_WIDE_DEN: assert property (
        wide_q && !order_int |=> o_loop.frac_den == $past(den_q))
        else $error("Wide mode denominator not passed whole.");
    AST_NARROW_UPPER: assert property (
        !wide_q |=> o_loop.frac_den[21:12] == 10'h000 && o_loop.frac_num[21:12] == 10'h000)
        else $error("Narrow mode upper fraction bits not ignored.");
    AST_HALVING: assert property (
        ##1 o_loop.output_halving == $past(halving_q))
        else $error("Output halving does not follow its bit.");
    AST_TOC_HIGH: assert property (
        toc_q == `SBL_TOC_HIGH |=> o_boost_lock_pin_oe && o_boost_lock_pin_o)
        else $error("Word three does not drive the pin high.");
    AST_SHORT_NO_BOOST: assert property (
        toc_q inside {`SBL_TOC_HIZ, 14'h0002, `SBL_TOC_HIGH} && !srst_wr
        |=> !boost_on ##1 o_filter.pump_code == $past(icp_q))
        else $error("Boost engaged with a short timeout word.");
    AST_LOAD: assert property (
        freq_wr && toc_long && !srst_wr |=> cnt_q == {$past(toc_q), 1'b0} && boost_on)
        else $error("Count not loaded with twice the word.");
    AST_BOOST_OUT: assert property (
        boost_on && toc_long |=> o_boost_lock_pin_oe && !o_boost_lock_pin_o
        && o_filter.pump_code == $past(boost_pump_current_code_q))
        else $error("Boost outputs not applied while counting.");
    AST_EXPIRE: assert property (
        st_q == sbl_pkg::SBL_ST_TIMED && cnt_q == 15'h0001 && i_pd_tick && !freq_wr
        && !wr_bst && toc_long |=> st_q == sbl_pkg::SBL_ST_STEADY ##1 o_boost_lock_pin_oe == 1'b0)
        else $error("Boost not released when the count expires.");
    AST_SRST_DOWN: assert property (
        srst_wr |=> srst_q ##1 o_power == '0)
        else $error("Soft reset does not power the part down.");
    AST_CAP_FOUR: assert property (
        flten_q && cap_q == 3'h4 |=> o_filter.c3_pf == `SBL_CAP_150
        && o_filter.c4_pf == `SBL_CAP_50)
        else $error("Capacitor code four decoded wrongly.");
    AST_FILTER_OFF: assert property (
        !flten_q |=> o_filter.r1_kohm == 6'h00 && o_filter.r2_kohm == 6'h00
        && o_filter.c3_pf + o_filter.c4_pf == `SBL_CAP_SUM_OFF)
        else $error("Disabled filter not shorted to 200 pF.");
    AST_ORDER_INT: assert property (
        order_int |=> o_loop.mod_reset && o_loop.frac_num == `SBL_RST_FRAC)
        else $error("Integer mode keeps fractional settings.");
endmodule
`default_nettype wire

/* File: synth_config_and_boost_lock_timer_tb.sv */
`include "sbl_defs.svh"
`default_nettype none
module synth_config_and_boost_lock_timer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_pd_tick = 1'b0;
    logic rd_taken = 1'b0;
    wire logic [7:0] addr;
    wire logic [31:0] wdata;
    wire logic wr_stb;
    wire logic rd_stb;
    logic [31:0] rdata;
    sbl_pkg::sbl_loop_s lp;
    sbl_pkg::sbl_filter_s fl;
    sbl_pkg::sbl_power_s pw;
    logic pin_o;
    logic pin_oe;
    int error_cnt = 0;
    int n_checks = 0;
    logic [31:0] exp_q [$];
    logic [31:0] seed = 32'he33c;
    logic [21:0] num;
    logic [21:0] fraction_denominator;
    logic [7:0] ca_t [8] = '{8'h32, 8'h32, 8'h32, 8'h64, 8'h96, 8'h64, 8'h32, 8'h32};
    logic [7:0] cb_t [8] = '{8'h32, 8'h64, 8'h96, 8'h32, 8'h32, 8'h64, 8'h96, 8'h96};
    sbl_host_model sbl_host_model_i (
        .i_clk(i_core_clk),
        .o_addr(addr),
        .o_wdata(wdata),
        .o_wr_stb(wr_stb),
        .o_rd_stb(rd_stb)
    );
    sbl_synth_cfg sbl_synth_cfg_i (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_addr(addr),
        .i_wdata(wdata),
        .i_wr_stb(wr_stb),
        .i_rd_stb(rd_stb),
        .o_rdata(rdata),
        .i_pd_tick(i_pd_tick),
        .o_loop(lp),
        .o_filter(fl),
        .o_power(pw),
        .o_boost_lock_pin_o(pin_o),
        .o_boost_lock_pin_oe(pin_oe)
    );
    always #10 i_core_clk = ~i_core_clk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
        begin
            $display("NO MISMATCHES");
        end
        else
        begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sbl_host_model_i.wr(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        sbl_host_model_i.rd(a);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge i_core_clk);
            i_pd_tick <= 1'b1;
            @(posedge i_core_clk);
            i_pd_tick <= 1'b0;
        end
    endtask
    task automatic bchk(input logic on);
        chk("pump", on ? 64'h5 : 64'h2, fl.pump_code);
        chk("res", on ? {6'h28, 6'h0a} : {6'h14, 6'h1e}, {fl.r1_kohm, fl.r2_kohm});
        chk("pin_oe", on, pin_oe);
        if (on)
        begin
            chk("pin_o", 0, pin_o);
        end
    endtask
    always @(posedge i_core_clk) rd_taken <= rd_stb;
    always @(negedge i_core_clk)
    begin
        if (rd_taken)
        begin
            chk("rdata", exp_q.pop_front(), rdata);
        end
    end
    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        step(2);
        chk("power", 64'h7f, pw);
        chk("select_a", sbl_pkg::SBL_DITH_WEAK, lp.select_a);
        chk("filter", {1'b1, 6'h0a, 6'h0a, 8'h32, 8'h32}, fl[28:0]);
        chk("pin_oe", 0, pin_oe);
        num = 22'(xs());
        fraction_denominator = 22'(xs());
        wr(`SBL_OFF_NUM, {10'h0, num});
        wr(`SBL_OFF_DEN, {10'h0, fraction_denominator});
        wr(`SBL_OFF_CFG, {25'h0, 5'h1d, sbl_host_model_i.pick_select_a(num)});
        step(2);
        chk("num", num, lp.frac_num);
        chk("den", fraction_denominator, lp.frac_den);
        chk("select_a", (num == 0) ? sbl_pkg::SBL_DITH_OFF : sbl_pkg::SBL_DITH_STRONG, lp.select_a);
        rd(`SBL_OFF_CFG, (num == 0) ? 32'h77 : 32'h76);
        wr(`SBL_OFF_CFG, 32'h78);
        step(2);
        chk("num", num[11:0], lp.frac_num);
        chk("den", fraction_denominator[11:0], lp.frac_den);
        chk("half", 1, lp.output_halving);
        chk("select_a", sbl_pkg::SBL_DITH_WEAK, lp.select_a);
        wr(`SBL_OFF_CFG, 32'h73);
        step(2);
        chk("half", 0, lp.output_halving);
        chk("select_a", sbl_pkg::SBL_DITH_OFF, lp.select_a);
        wr(`SBL_OFF_CFG, 32'h53);
        step(2);
        chk("order", {1'b1, 44'h0}, {lp.mod_reset, lp.frac_num, lp.frac_den});
        wr(`SBL_OFF_CFG, 32'h73);
        for (int i = 0; i < 8; i++)
        begin
            wr(`SBL_OFF_FLT, i);
            step(2);
            chk("caps", {ca_t[i], cb_t[i]}, {fl.c3_pf, fl.c4_pf});
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(`SBL_OFF_FLT, {k[1:0], k[1:0], k[1:0], k[1:0], 3'h0});
            step(2);
            chk("res", {2{6'((k + 1) * 10)}}, {fl.r1_kohm, fl.r2_kohm});
        end
        wr(`SBL_OFF_CFG, 32'h33);
        step(2);
        chk("poles", 0, fl.poles_on);
        chk("capsum", 64'hc8, fl.c3_pf + fl.c4_pf);
        chk("res_off", 0, {fl.r1_kohm, fl.r2_kohm});
        wr(`SBL_OFF_CFG, 32'h73);
        wr(`SBL_OFF_FLT, 32'h168);
        for (int w = 0; w < 4; w++)
        begin
            wr(`SBL_OFF_BST, 32'h94000 | w);
            wr(`SBL_OFF_NUM, 32'h1);
            tick(10);
            step(2);
            chk("pin_oe", w != 0, pin_oe);
            if (w != 0)
            begin
                chk("pin_o", w == 3, pin_o);
            end
            chk("pump", (w == 1) ? 5 : 2, fl.pump_code);
        end
        wr(`SBL_OFF_BST, 32'h94004);
        wr(`SBL_OFF_NUM, 32'h2);
        step(2);
        bchk(1'b1);
        tick(5);
        wr(`SBL_OFF_DEN, 32'h3);
        tick(7);
        step(3);
        bchk(1'b1);
        tick(1);
        step(3);
        bchk(1'b0);
        rd(`SBL_OFF_STAT, 0);
        wr(`SBL_OFF_PWR, 32'h80);
        step(2);
        chk("power", 0, pw);
        rd(`SBL_OFF_CFG, 32'h70);
        rd(`SBL_OFF_BST, 0);
        sbl_host_model_i.init(7'h55);
        step(2);
        chk("power", 64'h55, pw);
        rd(8'h1c, 0);
        step(3);
        tally_and_finish();
    end
endmodule
`default_nettype wire
